// ### hw/rps_pkg.sv
// Constants shared by the reset, power-down and shift-clock block.
// Assumes a single 50 MHz clock standing in for the master clock.
package rps_pkg;
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned SCLK_DIV       = 4;
   localparam int unsigned WORD_BITS      = 16;
   localparam int unsigned REG_COUNT      = 9;
   localparam int unsigned REG_W          = 8;
   // Default register contents: A, B select 16 kHz conversion, 7.2 kHz band
   localparam logic [7:0]  DFLT_NOOP      = 8'h00;
   localparam logic [7:0]  DFLT_A         = 8'h12;
   localparam logic [7:0]  DFLT_B         = 8'h12;
   localparam logic [7:0]  DFLT_APRIME    = 8'h00;
   localparam logic [7:0]  DFLT_GAIN      = 8'h00;
   localparam logic [7:0]  DFLT_ANALOG    = 8'h00;
   localparam logic [7:0]  DFLT_DIGITAL   = 8'h00;
   localparam logic [7:0]  DFLT_FSD       = 8'h00;
   localparam logic [7:0]  DFLT_FSNUM     = 8'h01;
   localparam logic [3:0]  ADDR_LSB       = 4'h8;
   localparam logic [1:0]  DIV_HALF       = 2'h1;
   localparam logic [1:0]  DIV_LAST       = 2'h3;
   localparam logic [4:0]  BITS_LAST      = 5'h0f;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} xfer_e;
endpackage : rps_pkg

// ### hw/reg_store.sv
// Small register store holding the programmed configuration words.
// Assumes writes and reads on the same clock; read data is registered.
`timescale 1ns/1ps
module reg_store #(
   parameter int unsigned DEPTH = rps_pkg::REG_COUNT,
   parameter int unsigned WIDTH = rps_pkg::REG_W
) (
   input  wire logic                     clk_i,
   input  wire logic                     nrst_i,
   input  wire logic                     we_i,
   input  wire logic [3:0]               waddr_i,
   input  wire logic [WIDTH-1:0]         wdata_i,
   input  wire logic [3:0]               raddr_i,
   output logic      [WIDTH-1:0]         rdata_o
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] dflt  [DEPTH];

   assign dflt[0] = rps_pkg::DFLT_NOOP;
   assign dflt[1] = rps_pkg::DFLT_A;
   assign dflt[2] = rps_pkg::DFLT_B;
   assign dflt[3] = rps_pkg::DFLT_APRIME;
   assign dflt[4] = rps_pkg::DFLT_GAIN;
   assign dflt[5] = rps_pkg::DFLT_ANALOG;
   assign dflt[6] = rps_pkg::DFLT_DIGITAL;
   assign dflt[7] = rps_pkg::DFLT_FSD;
   assign dflt[8] = rps_pkg::DFLT_FSNUM;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_word
         // Reset loads defaults; power-down never touches the store
         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               mem_r[g] <= dflt[g];
            end else if (we_i && (waddr_i == 4'(g))) begin
               mem_r[g] <= wdata_i;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= '0;
      end else if (raddr_i < 4'(DEPTH)) begin
         rdata_o <= mem_r[raddr_i];
      end else begin
         rdata_o <= '0;
      end
   end
endmodule : reg_store

// ### hw/reset_powerdown_shift_clock.sv
// Reset, power-down and shift-clock control with 16-bit serial framing.
// Assumes clk_i is the master clock; all input pins except nrst_i and tx_word_i pass two synchronising flops.
// Overview of operation
// - Low sleep input powers down but keeps every programmed register value.
// - Sleep released: operation resumes from retained state, no reprogramming.
// - Reset clears internal counters and sets control registers to their defaults.
// - Reset loads defaults, enters preset state, restarts serial link cleanly.
// - Defaults give 7.2 kHz bandwidth and default rate at nominal clock.
// - Shift clock moves serial data only within the frame-sync interval.
// - Master mode drives shift clock at master clock divided by four.
// - Master-select high makes the device master, low makes it slave.
// - Falling frame sync starts 16-bit exchange; slave sync low one period.
`timescale 1ns/1ps
module reset_powerdown_shift_clock #(
   parameter int unsigned WORD_BITS = rps_pkg::WORD_BITS
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        sleep_n_pin_i,
   input  wire logic        master_sel_i,
   input  wire logic        sclk_i,
   output logic             sclk_o,
   output logic             sclk_oe_o,
   input  wire logic        frame_sync_n_i,
   output logic             frame_sync_n_o,
   output logic             frame_sync_n_oe_o,
   input  wire logic        din_i,
   output logic             dout_o,
   input  wire logic [15:0] tx_word_i,
   output logic [15:0]      rx_word_o,
   output logic             rx_valid_o,
   output logic [7:0]       cfg_b_o,
   output logic             awake_o
);
   logic [1:0] sleep_s_r, msel_s_r, sclk_s_r, fs_s_r, din_s_r;
   logic       sclk_d_r, fs_d_r;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sleep_s_r <= '0;
         msel_s_r  <= '0;
         sclk_s_r  <= '0;
         fs_s_r    <= 2'h3;
         din_s_r   <= '0;
         sclk_d_r  <= 1'b0;
         fs_d_r    <= 1'b1;
      end else begin
         sleep_s_r <= {sleep_s_r[0], sleep_n_pin_i};
         msel_s_r  <= {msel_s_r[0], master_sel_i};
         sclk_s_r  <= {sclk_s_r[0], sclk_i};
         fs_s_r    <= {fs_s_r[0], frame_sync_n_i};
         din_s_r   <= {din_s_r[0], din_i};
         sclk_d_r  <= sclk_s_r[1];
         fs_d_r    <= fs_s_r[1];
      end
   end

   wire awake    = sleep_s_r[1];
   wire is_mast  = msel_s_r[1];

   // Divide-by-four shift clock generator, held at zero while asleep
   logic [1:0] div_r;
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !awake) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end
   wire msclk      = div_r[1];
   // Data in lags two sync flops, so it is taken at the end of its bit
   wire m_rise     = awake && (div_r == rps_pkg::DIV_LAST);
   wire m_fall     = awake && (div_r == rps_pkg::DIV_LAST);
   wire s_rise     = awake && sclk_s_r[1] && !sclk_d_r;
   wire s_fall     = awake && !sclk_s_r[1] && sclk_d_r;
   wire sh_rise    = is_mast ? m_rise : s_rise;
   wire sh_fall    = is_mast ? m_fall : s_fall;

   rps_pkg::xfer_e st_r;
   logic [4:0]     bit_r;
   logic [15:0]    sh_in_r, sh_out_r;
   logic           fs_out_r;
   logic           go_r;

   wire fs_fell    = !fs_s_r[1] && fs_d_r;
   wire start      = is_mast ? (st_r == rps_pkg::ST_IDLE && m_fall) : fs_fell;
   wire last_bit   = bit_r == rps_pkg::BITS_LAST;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_r       <= rps_pkg::ST_IDLE;
         bit_r      <= '0;
         sh_in_r    <= '0;
         sh_out_r   <= '0;
         fs_out_r   <= 1'b1;
         rx_word_o  <= '0;
         rx_valid_o <= 1'b0;
         go_r       <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         case (st_r)
            rps_pkg::ST_IDLE: begin
               if (start) begin
                  st_r     <= rps_pkg::ST_SHIFT;
                  bit_r    <= '0;
                  sh_out_r <= tx_word_i;
                  fs_out_r <= 1'b0;
                  go_r     <= 1'b1;
               end
            end
            rps_pkg::ST_SHIFT: begin
               if (sh_rise) begin
                  sh_in_r <= {sh_in_r[14:0], din_s_r[1]};
               end
               if (sh_fall) begin
                  if (last_bit) begin
                     st_r     <= rps_pkg::ST_DONE;
                     fs_out_r <= 1'b1;
                  end else begin
                     bit_r    <= bit_r + 5'h01;
                     sh_out_r <= {sh_out_r[14:0], 1'b0};
                  end
               end
            end
            rps_pkg::ST_DONE: begin
               rx_word_o  <= sh_in_r;
               rx_valid_o <= 1'b1;
               go_r       <= 1'b0;
               st_r       <= rps_pkg::ST_IDLE;
            end
            default: st_r <= rps_pkg::ST_IDLE;
         endcase
      end
   end

   wire in_frame = (st_r == rps_pkg::ST_SHIFT) && awake;

   // Output pins driven from flops
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sclk_o            <= 1'b0;
         sclk_oe_o         <= 1'b0;
         frame_sync_n_o    <= 1'b1;
         frame_sync_n_oe_o <= 1'b0;
         dout_o            <= 1'b0;
      end else begin
         sclk_o            <= is_mast && awake && msclk;
         sclk_oe_o         <= is_mast;
         frame_sync_n_o    <= fs_out_r || !awake;
         frame_sync_n_oe_o <= is_mast;
         dout_o            <= in_frame && sh_out_r[15];
      end
   end

   // Configuration held across sleep; written from a received command word
   logic [7:0] cfg_rd;
   wire        cfg_we = rx_valid_o && awake;
   reg_store u_store (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .we_i    (cfg_we),
      .waddr_i (rx_word_o[11:8]),
      .wdata_i (rx_word_o[7:0]),
      .raddr_i (4'h2),
      .rdata_o (cfg_rd)
   );
   assign cfg_b_o = cfg_rd;
   assign awake_o = awake;

   // Assertions
   logic nrst_d_r;
   always_ff @(posedge clk_i) nrst_d_r <= nrst_i;

   property p_div_run;
      @(posedge clk_i) disable iff (!nrst_i)
      (awake && $past(awake) && div_r == 2'h0) |=> div_r == rps_pkg::DIV_HALF;
   endproperty
   a_div_run: assert property (p_div_run) else $error("divider stalled");

   property p_sclk_quiet;
      @(posedge clk_i) disable iff (!nrst_i)
      (!awake) [*2] |=> !sclk_o;
   endproperty
   a_sclk_quiet: assert property (p_sclk_quiet) else $error("sclk while asleep");

   property p_dout_quiet;
      @(posedge clk_i) disable iff (!nrst_i)
      !in_frame |=> !dout_o;
   endproperty
   a_dout_quiet: assert property (p_dout_quiet) else $error("dout out of frame");

   property p_oe_master;
      @(posedge clk_i) disable iff (!nrst_i)
      $stable(is_mast) |=> sclk_oe_o == $past(is_mast);
   endproperty
   a_oe_master: assert property (p_oe_master) else $error("sclk enable wrong");

   property p_reset_idle;
      @(posedge clk_i) !nrst_d_r && nrst_i |-> st_r == rps_pkg::ST_IDLE && bit_r == 5'h00;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

   property p_reset_dflt;
      @(posedge clk_i) !nrst_d_r && nrst_i |=> cfg_b_o == rps_pkg::DFLT_B;
   endproperty
   a_reset_dflt: assert property (p_reset_dflt) else $error("default B missing");

   property p_sleep_keeps;
      @(posedge clk_i) disable iff (!nrst_i)
      nrst_d_r && !awake && $past(!awake) |=> $stable(cfg_b_o);
   endproperty
   a_sleep_keeps: assert property (p_sleep_keeps) else $error("cfg lost asleep");

   sequence s_start;
      st_r == rps_pkg::ST_IDLE && start;
   endsequence
   property p_start;
      @(posedge clk_i) disable iff (!nrst_i) s_start |=> st_r == rps_pkg::ST_SHIFT;
   endproperty
   a_start: assert property (p_start) else $error("frame not started");

   // Counts awake master cycles spent shifting in the current frame
   logic [6:0] frame_len_r;
   wire  [6:0] len_last = 7'(WORD_BITS * rps_pkg::SCLK_DIV - 1);
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !awake || !is_mast || st_r != rps_pkg::ST_SHIFT) begin
         frame_len_r <= '0;
      end else begin
         frame_len_r <= frame_len_r + 7'h01;
      end
   end
   sequence s_frame_last;
      st_r == rps_pkg::ST_SHIFT && is_mast && awake && frame_len_r == len_last;
   endsequence
   property p_master_len;
      @(posedge clk_i) disable iff (!nrst_i) s_frame_last |=> st_r != rps_pkg::ST_SHIFT;
   endproperty
   a_master_len: assert property (p_master_len) else $error("frame length wrong");

   property p_resume;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(awake) |=> div_r == rps_pkg::DIV_HALF;
   endproperty
   a_resume: assert property (p_resume) else $error("no clean restart");
endmodule : reset_powerdown_shift_clock

// ### verif/serial_host.sv
// Serial partner: word source and sink, and shift clock source in slave mode.
// Assumes the bench selects the shared lines by the output enables.
`timescale 1ns/1ps
module serial_host (
   input  wire logic        clk_i,
   input  wire logic        sclk_w_i,
   input  wire logic        fs_w_i,
   input  wire logic        dout_i,
   input  wire logic [15:0] tx_i,
   output logic             sclk_o,
   output logic             fs_n_o,
   output logic             din_o,
   output logic [15:0]      got_o
);
   int          n = 16;
   logic [15:0] sh = 16'h0000;
   logic [15:0] rx = 16'h0000;
   initial begin
      sclk_o = 1'b0;
      fs_n_o = 1'b1;
      din_o  = 1'b0;
      got_o  = 16'h0000;
   end
   // Word is latched at the sync edge and sent msb first
   always @(negedge fs_w_i) begin
      n = 0;
      sh = tx_i;
      din_o = tx_i[15];
   end
   always @(posedge sclk_w_i) if (n < 16) begin
      rx = {rx[14:0], dout_i};
      n = n + 1;
      if (n == 16) got_o = rx;
   end
   always @(negedge sclk_w_i) begin
      if (n > 0 && n < 16) begin
         din_o = sh[15-n];
      end else if (n == 16) begin
         // Released data line shows the inverse so a stale bit cannot pass
         din_o = ~din_o;
         n = 17;
      end
   end
   task automatic slave_frame();
      @(negedge clk_i) fs_n_o = 1'b0;
      repeat (16) begin
         repeat (4) @(negedge clk_i);
         sclk_o = 1'b1;
         repeat (4) @(negedge clk_i);
         sclk_o = 1'b0;
      end
      fs_n_o = 1'b1;
   endtask : slave_frame
endmodule : serial_host

// ### verif/reset_powerdown_shift_clock_tb_top.sv
// Self-checking bench for the reset, power-down and shift-clock block.
// Assumes rps_pkg and the serial_host partner model.
`timescale 1ns/1ps
module reset_powerdown_shift_clock_tb_top;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        sleep_n_i = 1'b1;
   logic        msel = 1'b1;
   logic [15:0] tx_word_i = 16'h0000;
   logic [15:0] host_tx = 16'h0000;
   logic [15:0] hw;
   logic [7:0]  exp_b = rps_pkg::DFLT_B;
   logic        sclk_o, sclk_oe, fs_o, fs_oe, dout_o, rx_valid_o, awake_o, h_sclk, h_fs, din_w;
   logic [15:0] rx_word_o, h_rx;
   logic [7:0]  cfg_b_o;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cycles = 0;
   wire         sclk_w = sclk_oe ? sclk_o : h_sclk;
   wire         fs_w = fs_oe ? fs_o : h_fs;
   reset_powerdown_shift_clock dut (.clk_i(clk_i), .nrst_i(nrst_i), .sleep_n_pin_i(sleep_n_i),
      .master_sel_i(msel), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe),
      .frame_sync_n_i(fs_w), .frame_sync_n_o(fs_o), .frame_sync_n_oe_o(fs_oe), .din_i(din_w),
      .dout_o(dout_o), .tx_word_i(tx_word_i), .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o),
      .cfg_b_o(cfg_b_o), .awake_o(awake_o));
   serial_host host (.clk_i(clk_i), .sclk_w_i(sclk_w), .fs_w_i(fs_w), .dout_i(dout_o),
      .tx_i(host_tx), .sclk_o(h_sclk), .fs_n_o(h_fs), .din_o(din_w), .got_o(h_rx));
   initial forever #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic chk_w(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_w
   task automatic chk_b(string what, logic exp, logic got);
      chk_w(what, {15'h0000, exp}, {15'h0000, got});
   endtask : chk_b
   function automatic logic [7:0] exp_cfg(logic [15:0] w, logic [7:0] old);
      return (w[11:8] == 4'h2) ? w[7:0] : old;
   endfunction : exp_cfg
   task automatic wait_rx();
      for (int k = 0; k < 400 && rx_valid_o !== 1'b1; k++) @(negedge clk_i);
      chk_b("rx_valid", 1'b1, rx_valid_o);
      @(negedge clk_i);
   endtask : wait_rx
   task automatic xfer(bit slave, logic [15:0] w);
      logic [15:0] dw;
      hw = (w != 16'h0000) ? w : {4'h0, ($urandom % 2) ? 4'h2 : 4'(9 + $urandom % 7), 8'($urandom)};
      dw = 16'($urandom);
      @(negedge clk_i);
      tx_word_i = dw;
      host_tx = hw;
      if (slave) fork
         host.slave_frame();
         wait_rx();
      join
      else begin
         wait_rx();
         wait_rx();
      end
      chk_w("rx_word", hw, rx_word_o);
      chk_w("host_rx", dw, h_rx);
      repeat (3) @(negedge clk_i);
      exp_b = exp_cfg(hw, exp_b);
      chk_w("cfg_b", {8'h00, exp_b}, {8'h00, cfg_b_o});
   endtask : xfer
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   initial begin
      logic s [8];
      void'($urandom(14490));
      repeat (6) @(negedge clk_i);
      chk_b("sclk_oe", 1'b0, sclk_oe);
      nrst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk_w("cfg_b", {8'h00, rps_pkg::DFLT_B}, {8'h00, cfg_b_o});
      chk_b("sclk_oe", 1'b1, sclk_oe);
      for (int i = 0; i < 8; i++) begin
         s[i] = sclk_o;
         @(negedge clk_i);
      end
      for (int i = 0; i < 4; i++) begin
         chk_b("sclk_period", s[i], s[i+4]);
         chk_b("sclk_half", ~s[i], s[i+2]);
      end
      $display("test reset done");
      xfer(1'b0, 16'h02ff);
      xfer(1'b0, 16'h09aa);
      for (int i = 0; i < 3; i++) xfer(1'b0, 16'h0000);
      $display("test master done");
      sleep_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      chk_b("awake", 1'b0, awake_o);
      repeat (40) begin
         @(negedge clk_i);
         chk_b("sclk_quiet", 1'b0, sclk_o);
         chk_b("dout_quiet", 1'b0, dout_o);
         chk_b("fs_quiet", 1'b1, fs_o);
      end
      sleep_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk_w("cfg_kept", {8'h00, exp_b}, {8'h00, cfg_b_o});
      xfer(1'b0, 16'h0000);
      $display("test sleep done");
      // Leave master mode between frames so no frame is cut
      while (rx_valid_o !== 1'b1) @(negedge clk_i);
      msel = 1'b0;
      repeat (8) @(negedge clk_i);
      chk_b("sclk_oe", 1'b0, sclk_oe);
      xfer(1'b1, 16'h0233);
      xfer(1'b1, 16'h0000);
      $display("test slave done");
      nrst_i = 1'b0;
      repeat (6) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk_w("cfg_b", {8'h00, rps_pkg::DFLT_B}, {8'h00, cfg_b_o});
      $display("test second reset done");
      conclude();
   end
endmodule : reset_powerdown_shift_clock_tb_top
